// File: common/rfrt_pkg.sv
// Shared constants, field layouts and carrier types of the receive FIFO and RAM test block
`default_nettype none

package rfrt_pkg;

	// Shared FIFO RAM geometry
	localparam int RAM_DEPTH = 512; // Entries in the shared RAM
	localparam int RAM_WIDTH = 33; // Control bit plus one quadlet
	localparam int PTR_W = 9; // Bits of a RAM address
	localparam int DATA_W = 32; // Host data width
	localparam int ADDR_W = 12; // APB address width used by the decoder
	localparam logic [9:0] RAM_DEPTH_W = 10'h200; // Depth at count width

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000; // Receive control and trigger size
	localparam logic [11:0] OFF_PART = 12'h004; // Transmit FIFO partition sizes
	localparam logic [11:0] OFF_RAMST = 12'h008; // RAM test control and status
	localparam logic [11:0] OFF_RXST = 12'h00C; // Receive FIFO status
	localparam logic [11:0] OFF_RXDATA = 12'h0C0; // Receive FIFO data port

	// Control register fields
	localparam int CTRL_TRIG_EN = 0; // Trigger enable
	localparam int CTRL_FLUSH_BAD = 1; // Flush bad packets
	localparam int CTRL_SNOOP = 2; // Snoop enable
	localparam int CTRL_TRIG_LO = 16; // Trigger size, nine bits

	// Partition register fields
	localparam int PART_ASYNC_LO = 0; // Async transmit FIFO size, nine bits
	localparam int PART_ISO_LO = 16; // Iso transmit FIFO size, nine bits

	// RAM test register fields
	localparam int RAMST_CON_ERR = 2; // Control error, read only
	localparam int RAMST_ADR_CLR = 3; // Address clear, self clearing
	localparam int RAMST_CTL1 = 4; // Control value setting
	localparam int RAMST_TEST = 5; // RAM test enable
	localparam int RAMST_ADR_LO = 16; // Address counter, nine bits

	// Receive status fields
	localparam int RXST_AVAIL = 0; // Committed data present
	localparam int RXST_TOKEN_TOP = 1; // Token on top
	localparam int RXST_PAC_COMP = 2; // Packet complete of the top block
	localparam int RXST_WCNT_LO = 16; // Block quadlet count, nine bits

	// Packet token fields
	localparam int TOK_SNPACK_LO = 7; // Snooped ack, four bits
	localparam int TOK_PAC_COMP = 11; // Packet complete
	localparam int TOK_SNOOP = 12; // Snoop enable copy
	localparam int TOK_SPD_LO = 13; // Received speed, two bits
	localparam int TOK_WCNT_LO = 15; // Block quadlet count, nine bits
	localparam int TOK_TCODE_LO = 24; // Transaction code, four bits
	localparam int TOK_ACK_LO = 28; // Ack sent, four bits

	// Fixed field values
	localparam logic [3:0] TCODE_SPECIAL = 4'hE; // Self-ID, PHY config, link-on
	localparam logic [3:0] ACK_NONE = 4'h0; // Ack for PHY config and link-on
	localparam logic [3:0] SNPACK_OFF = 4'h0; // Snooped ack without snoop
	localparam logic [8:0] SPLIT_MIN = 9'h005; // Trigger size must exceed this

	// Reset values
	localparam logic [8:0] ASYNC_SIZE_RST = 9'h080; // Async FIFO size after reset
	localparam logic [8:0] ISO_SIZE_RST = 9'h080; // Iso FIFO size after reset
	localparam logic [8:0] TRIG_SIZE_RST = 9'h000; // Trigger size after reset

	// One received quadlet with the attributes of its packet
	typedef struct packed {
		logic [31:0] data; // Quadlet as received
		logic last; // Final quadlet of the packet
		logic [3:0] tcode; // Received transaction code
		logic [1:0] speed; // 00 100, 01 200, 10 400 Mbit/s
		logic [3:0] ack; // Ack returned to the sender
		logic [3:0] snoopAck; // Ack seen on the bus while snooping
		logic special; // Self-ID, PHY config or link-on packet
		logic phyOrLink; // PHY config or link-on packet
		logic quadlet; // Quadlet read or write packet
	} rfrt_rx_s;

	// Receive write state
	typedef enum logic {RECV, TOKEN} rfrt_state_e;

endpackage

`default_nettype wire

// File: logic/rfrt_ram.sv
// Shared FIFO RAM with one write port and one registered read port
`default_nettype none

module rfrt_ram #(
	parameter int DEPTH = 512,
	parameter int WIDTH = 33,
	parameter int AW = 9
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	// Storage, no reset so it maps onto a block RAM
	logic [WIDTH-1:0] mem [DEPTH];

	// Write port
	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Read port returns old data on a same-address write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule // rfrt_ram

`default_nettype wire

// File: logic/rfrt_top.sv
// Receive FIFO read path, block builder and RAM test mode behind an APB slave
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none

module rfrt_top #(
	parameter int DEPTH = rfrt_pkg::RAM_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rfrt_pkg::ADDR_W-1:0] paddr,
	input wire logic [rfrt_pkg::DATA_W-1:0] pwdata,
	output logic [rfrt_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxValid,
	input wire rfrt_pkg::rfrt_rx_s rxBeat,
	output logic rxReady,
	output logic dataReadyEvent
);

	localparam int AW = rfrt_pkg::PTR_W;

	// Wrapping increment inside the receive region
	function automatic logic [AW-1:0] incPtr(input logic [AW-1:0] p, input logic [9:0] size);
		logic [9:0] nxt;
		nxt = {1'b0, p} + 10'h001;
		incPtr = (nxt >= size) ? '0 : nxt[AW-1:0];
	endfunction

	// Packet token from the attributes of the last beat of the block
	function automatic logic [31:0] buildToken(input rfrt_pkg::rfrt_rx_s a, input logic snoop,
		input logic done, input logic [8:0] cnt);
		logic [31:0] t;
		t = '0; // Bits 0 to 6 stay reserved as zero
		t[rfrt_pkg::TOK_SNPACK_LO +: 4] = snoop ? a.snoopAck : rfrt_pkg::SNPACK_OFF;
		t[rfrt_pkg::TOK_PAC_COMP] = done;
		t[rfrt_pkg::TOK_SNOOP] = snoop;
		t[rfrt_pkg::TOK_SPD_LO +: 2] = a.speed;
		t[rfrt_pkg::TOK_WCNT_LO +: 9] = cnt;
		t[rfrt_pkg::TOK_TCODE_LO +: 4] = a.special ? rfrt_pkg::TCODE_SPECIAL : a.tcode;
		t[rfrt_pkg::TOK_ACK_LO +: 4] = a.phyOrLink ? rfrt_pkg::ACK_NONE : a.ack;
		buildToken = t;
	endfunction

	// Software control
	logic trigEn; // Trigger enable
	logic flushBad; // Flush bad packets
	logic snoopEn; // Snoop enable
	logic [8:0] trigSize; // Block length limit when splitting
	logic [8:0] asyncSize; // Async transmit FIFO size
	logic [8:0] isoSize; // Iso transmit FIFO size
	logic ram_test_enable; // RAM test enable
	logic control_value_setting; // Control value setting
	logic control_error; // Control error
	logic [AW-1:0] adrCounter; // RAM test address counter

	// Receive FIFO state
	rfrt_pkg::rfrt_state_e state; // Write side state
	rfrt_pkg::rfrt_rx_s lastBeat; // Attributes of the newest beat
	logic pktEnd; // Current block closes its packet
	logic [AW-1:0] dataPtr; // Next free offset
	logic [AW-1:0] tokenPtr; // Reserved token offset of open block
	logic [AW-1:0] readPtr; // Host read offset
	logic [8:0] blkCount; // Quadlets in open block
	logic [9:0] stored; // Entries held, committed or not
	logic [9:0] avail; // Entries the host may read
	logic commitPend; // Token written, publish next cycle
	logic [9:0] commitCnt; // Entries of the block being published
	logic [32:0] ramQ; // RAM read data

	// APB decoding
	wire accessPh = psel & penable;
	wire wrAcc = accessPh & pwrite;
	wire rdAcc = accessPh & ~pwrite;
	wire selCtrl = (paddr == rfrt_pkg::OFF_CTRL);
	wire selPart = (paddr == rfrt_pkg::OFF_PART);
	wire selRamSt = (paddr == rfrt_pkg::OFF_RAMST);
	wire selRxSt = (paddr == rfrt_pkg::OFF_RXST);
	wire selData = (paddr == rfrt_pkg::OFF_RXDATA);
	wire mapped = selCtrl | selPart | selRamSt | selRxSt | selData;

	// Receive region placement and free space
	wire [AW-1:0] rxBase = asyncSize + isoSize;
	wire [9:0] rxSize = rfrt_pkg::RAM_DEPTH_W - {1'b0, rxBase};
	wire [9:0] freeSlots = rxSize - stored;
	wire openBlock = (blkCount == 9'h000);
	wire [9:0] needSlots = openBlock ? 10'h002 : 10'h001;

	// Splitting gate: never for special or quadlet packets
	wire splitOn = trigEn & ~flushBad & (trigSize > rfrt_pkg::SPLIT_MIN)
		& ~rxBeat.special & ~rxBeat.quadlet;
	wire [8:0] nextBlk = blkCount + 9'h001;
	wire blockEnd = rxBeat.last | (splitOn & (nextBlk == trigSize));

	// Receiver handshake, stalled whenever RAM test owns the RAM
	assign rxReady = (state == rfrt_pkg::RECV) & ~ram_test_enable & (freeSlots >= needSlots);
	wire rxAccept = rxValid & rxReady;
	wire [AW-1:0] wrOff = openBlock ? incPtr(dataPtr, rxSize) : dataPtr;
	wire tokenWr = (state == rfrt_pkg::TOKEN) & ~ram_test_enable;

	// Host side of the FIFO and of the test port
	wire testWr = wrAcc & selData & ram_test_enable;
	wire testRd = rdAcc & selData & ram_test_enable;
	wire pop = rdAcc & selData & ~ram_test_enable & (avail != 10'h000);
	wire tokenTop = ram_test_enable ? ramQ[32] : ((avail != 10'h000) & ramQ[32]);
	wire normTop = tokenTop & ~ram_test_enable;

	// RAM port selection; a test write takes the port only while the FIFO is frozen
	wire ramWrEn = testWr | rxAccept | tokenWr;
	wire [AW-1:0] ramWrAddr = testWr ? adrCounter
		: (tokenWr ? rxBase + tokenPtr : rxBase + wrOff);
	wire [32:0] ramWrData = testWr ? {control_value_setting, pwdata}
		: (tokenWr ? {1'b1, buildToken(lastBeat, snoopEn, pktEnd, blkCount)}
		: {1'b0, rxBeat.data});
	wire [AW-1:0] ramRdAddr = ram_test_enable ? adrCounter : rxBase + readPtr;

	// Count updates
	wire [9:0] addSlots = rxAccept ? needSlots : 10'h000;
	wire [9:0] popCnt = pop ? 10'h001 : 10'h000;
	wire [9:0] pubCnt = commitPend ? commitCnt : 10'h000;

	// Shared 512 x 33 RAM; bit 32 marks the first entry of a block
	rfrt_ram #(
		.DEPTH(DEPTH),
		.WIDTH(rfrt_pkg::RAM_WIDTH),
		.AW(AW)
	) u_ram (
		.core_clk(core_clk),
		.rst(rst),
		.wrEn(ramWrEn),
		.wrAddr(ramWrAddr),
		.wrData(ramWrData),
		.rdAddr(ramRdAddr),
		.rdData(ramQ)
	);

	// Zero wait states: the RAM is read during the setup cycle
	assign pready = 1'b1;

	// Read mux; unmapped addresses read zero and report an error
	always_comb begin
		prdata = '0;
		pslverr = psel & penable & ~mapped;
		if (selCtrl) begin
			prdata[rfrt_pkg::CTRL_TRIG_EN] = trigEn;
			prdata[rfrt_pkg::CTRL_FLUSH_BAD] = flushBad;
			prdata[rfrt_pkg::CTRL_SNOOP] = snoopEn;
			prdata[rfrt_pkg::CTRL_TRIG_LO +: 9] = trigSize;
		end else if (selPart) begin
			prdata[rfrt_pkg::PART_ASYNC_LO +: 9] = asyncSize;
			prdata[rfrt_pkg::PART_ISO_LO +: 9] = isoSize;
		end else if (selRamSt) begin
			// Address clear always reads back as zero
			prdata[rfrt_pkg::RAMST_CON_ERR] = control_error;
			prdata[rfrt_pkg::RAMST_CTL1] = control_value_setting;
			prdata[rfrt_pkg::RAMST_TEST] = ram_test_enable;
			prdata[rfrt_pkg::RAMST_ADR_LO +: 9] = adrCounter;
		end else if (selRxSt) begin
			prdata[rfrt_pkg::RXST_AVAIL] = (avail != 10'h000) & ~ram_test_enable;
			prdata[rfrt_pkg::RXST_TOKEN_TOP] = tokenTop;
			prdata[rfrt_pkg::RXST_PAC_COMP] = normTop & ramQ[rfrt_pkg::TOK_PAC_COMP];
			prdata[rfrt_pkg::RXST_WCNT_LO +: 9] = normTop ? ramQ[rfrt_pkg::TOK_WCNT_LO +: 9]
				: 9'h000;
		end else if (selData) begin
			// Empty FIFO reads zero and does not move the pointer
			prdata = (ram_test_enable | (avail != 10'h000)) ? ramQ[31:0] : '0;
		end
	end

	// Control and partition registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trigEn <= 1'b0;
			flushBad <= 1'b0;
			snoopEn <= 1'b0;
			trigSize <= rfrt_pkg::TRIG_SIZE_RST;
			asyncSize <= rfrt_pkg::ASYNC_SIZE_RST;
			isoSize <= rfrt_pkg::ISO_SIZE_RST;
		end else if (wrAcc & selCtrl) begin
			trigEn <= pwdata[rfrt_pkg::CTRL_TRIG_EN];
			flushBad <= pwdata[rfrt_pkg::CTRL_FLUSH_BAD];
			snoopEn <= pwdata[rfrt_pkg::CTRL_SNOOP];
			trigSize <= pwdata[rfrt_pkg::CTRL_TRIG_LO +: 9];
		end else if (wrAcc & selPart) begin
			// Repartitioning with data stored corrupts the FIFO; software must drain first
			asyncSize <= pwdata[rfrt_pkg::PART_ASYNC_LO +: 9];
			isoSize <= pwdata[rfrt_pkg::PART_ISO_LO +: 9];
		end
	end

	// RAM test mode bits
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ram_test_enable <= 1'b0;
			control_value_setting <= 1'b0;
		end else if (wrAcc & selRamSt) begin
			ram_test_enable <= pwdata[rfrt_pkg::RAMST_TEST];
			control_value_setting <= pwdata[rfrt_pkg::RAMST_CTL1];
		end
	end

	// Address counter: clear beats a load, a load beats the step
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			adrCounter <= '0;
		end else if (wrAcc & selRamSt & pwdata[rfrt_pkg::RAMST_ADR_CLR]) begin
			adrCounter <= '0;
		end else if (wrAcc & selRamSt) begin
			adrCounter <= pwdata[rfrt_pkg::RAMST_ADR_LO +: 9];
		end else if (testWr | testRd) begin
			adrCounter <= adrCounter + 9'h001;
		end
	end

	// Control error is sticky; the clear bit itself is never stored
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			control_error <= 1'b0;
		end else if (testRd & (ramQ[32] != control_value_setting)) begin
			control_error <= 1'b1;
		end else if (wrAcc & selRamSt & pwdata[rfrt_pkg::RAMST_ADR_CLR]) begin
			control_error <= 1'b0;
		end
	end

	// Block builder: data goes behind a reserved token slot, token closes the block
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= rfrt_pkg::RECV;
			lastBeat <= '0;
			pktEnd <= 1'b0;
			dataPtr <= '0;
			tokenPtr <= '0;
			blkCount <= '0;
		end else begin
			case (state)
				rfrt_pkg::RECV: begin
					if (rxAccept) begin
						lastBeat <= rxBeat;
						pktEnd <= rxBeat.last;
						blkCount <= nextBlk;
						dataPtr <= incPtr(wrOff, rxSize);
						if (openBlock) begin
							tokenPtr <= dataPtr;
						end
						if (blockEnd) begin
							state <= rfrt_pkg::TOKEN;
						end
					end
				end
				rfrt_pkg::TOKEN: begin
					// Held here while RAM test owns the port
					if (!ram_test_enable) begin
						blkCount <= '0;
						state <= rfrt_pkg::RECV;
					end
				end
				default: begin
					state <= rfrt_pkg::RECV;
				end
			endcase
		end
	end

	// Publish a block one cycle after its token, so status never sees a stale token
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			commitPend <= 1'b0;
			commitCnt <= '0;
			dataReadyEvent <= 1'b0;
		end else begin
			commitPend <= tokenWr;
			commitCnt <= {1'b0, blkCount} + 10'h001;
			dataReadyEvent <= commitPend;
		end
	end

	// Occupancy and host pointer; frozen in test mode since no beat or pop occurs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stored <= '0;
			avail <= '0;
			readPtr <= '0;
		end else begin
			stored <= stored + addSlots - popCnt;
			avail <= avail + pubCnt - popCnt;
			if (pop) begin
				readPtr <= incPtr(readPtr, rxSize);
			end
		end
	end

endmodule // rfrt_top

`default_nettype wire

// File: sim/rfrt_top_assertions.sv
// Concurrent checks on the ports of the receive FIFO and RAM test block
`default_nettype none

module rfrt_top_checker #(
	parameter int DEPTH = rfrt_pkg::RAM_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rfrt_pkg::ADDR_W-1:0] paddr,
	input wire logic [rfrt_pkg::DATA_W-1:0] pwdata,
	input wire logic [rfrt_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxValid,
	input wire rfrt_pkg::rfrt_rx_s rxBeat,
	input wire logic rxReady,
	input wire logic dataReadyEvent
);
	timeunit 1ns;
	timeprecision 1ps;

	wire acc = psel && penable; // Access phase of a transfer
	wire stAcc = acc && paddr == rfrt_pkg::OFF_RAMST; // RAM test register access
	wire mapped = paddr inside {rfrt_pkg::OFF_CTRL, rfrt_pkg::OFF_PART, rfrt_pkg::OFF_RAMST,
		rfrt_pkg::OFF_RXST, rfrt_pkg::OFF_RXDATA};
	wire lastIn = rxValid && rxReady && rxBeat.last; // Packet end taken
	logic testOn; // Shadow of the test enable
	logic [8:0] adrCnt; // Shadow of the RAM address counter
	logic errClean; // No compare since the last address clear

	// Shadow state follows host writes; only test-mode data accesses move the counter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			testOn <= 1'b0;
			adrCnt <= 9'h000;
			errClean <= 1'b1;
		end else if (stAcc && pwrite) begin
			testOn <= pwdata[5];
			adrCnt <= pwdata[3] ? 9'h000 : pwdata[24:16];
			errClean <= errClean | pwdata[3];
		end else if (acc && paddr == rfrt_pkg::OFF_RXDATA && testOn) begin
			adrCnt <= adrCnt + 9'h001;
			errClean <= errClean & pwrite;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_unmapped_refused: assert property (
		acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
		else $error("unmapped access not refused");
	a_mapped_clean: assert property (acc && mapped |-> !pslverr && pready)
		else $error("mapped access refused or stalled");
	a_event_pulse: assert property (dataReadyEvent |=> !dataReadyEvent)
		else $error("data ready event longer than one cycle");
	a_event_after_end: assert property (lastIn && !testOn |-> ##[1:4] dataReadyEvent)
		else $error("no data ready event after a stored packet");
	a_token_stall: assert property (lastIn |=> !rxReady)
		else $error("receiver not stalled for the token slot");
	a_test_no_rx: assert property (testOn |-> !rxReady)
		else $error("receiver accepted beats in RAM test mode");
	a_counter_read: assert property (
		stAcc && !pwrite |-> prdata[24:16] == adrCnt && !prdata[3])
		else $error("RAM address counter or clear bit reads wrong");
	a_clear_error: assert property (stAcc && !pwrite && errClean |-> !prdata[2])
		else $error("control error not cleared");
endmodule // rfrt_top_checker

bind rfrt_top rfrt_top_checker #(.DEPTH(DEPTH)) u_checker (
	.core_clk(core_clk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.rxValid(rxValid),
	.rxBeat(rxBeat),
	.rxReady(rxReady),
	.dataReadyEvent(dataReadyEvent)
);

`default_nettype wire

// File: sim/rfrt_rx_source.sv
// Behavioural link receiver that offers quadlets to the block
`default_nettype none

module rfrt_rx_source (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rxReady,
	output logic rxValid,
	output rfrt_pkg::rfrt_rx_s rxBeat
);
	timeunit 1ns;
	timeprecision 1ps;

	rfrt_pkg::rfrt_rx_s q[$]; // Beats waiting to go out
	bit slow = 1'b0; // Offer a beat only every other cycle
	bit tick = 1'b0; // Alternating cycle marker

	// An offered beat holds until taken; idle data flips so stale values never pass
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxValid <= 1'b0;
			rxBeat <= '0;
		end else begin
			if (rxValid && rxReady) begin
				void'(q.pop_front());
			end
			tick <= ~tick;
			if (rxValid && !rxReady) begin
				rxValid <= 1'b1;
			end else if (q.size() > 0 && !(slow && tick)) begin
				rxValid <= 1'b1;
				rxBeat <= q[0]; // Attributes ride on every beat
			end else begin
				rxValid <= 1'b0;
				rxBeat.data <= ~rxBeat.data;
			end
		end
	end
endmodule // rfrt_rx_source

`default_nettype wire

// File: sim/rfrt_top_test.sv
// Self-checking bench for the receive FIFO and RAM test block
`default_nettype none

module rfrt_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxValid;
	rfrt_pkg::rfrt_rx_s rxBeat;
	logic rxReady;
	logic dataReadyEvent;
	int n_errors = 0;
	int check_count = 0;
	int evCount = 0; // Events seen
	int evExp = 0; // Events the model expects
	int cyc = 0;
	logic snp = 1'b0; // Model copy of snoop enable
	logic [31:0] rnd = 32'h1307_c313;
	logic [32:0] expQ[$]; // Model of the receive FIFO: token flag and word
	logic [31:0] ramD[4]; // Model of the RAM words under test
	logic [31:0] r;
	logic e;
	rfrt_pkg::rfrt_rx_s a;

	rfrt_top DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxValid(rxValid), .rxBeat(rxBeat), .rxReady(rxReady),
		.dataReadyEvent(dataReadyEvent));
	rfrt_rx_source src (.core_clk(core_clk), .rst(rst), .rxReady(rxReady),
		.rxValid(rxValid), .rxBeat(rxBeat));

	// Free-running clock
	always #5 core_clk = ~core_clk;

	// Event counting and hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (dataReadyEvent === 1'b1) begin
			evCount++;
		end
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high, the hang guard ends a stuck wait
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
		output logic [31:0] rv, output logic ev);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d, r, e);
	endtask

	task rd(input logic [11:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h0000_0000, r, e);
		chk(r, x);
	endtask

	// Queue a packet at the receiver and build the blocks the FIFO should hold
	task send(input int n, input int trig);
		rfrt_pkg::rfrt_rx_s x;
		logic [31:0] blk[$];
		int b;
		b = (trig > 5 && !a.special && !a.quadlet) ? trig : n;
		@(negedge core_clk);
		for (int k = 0; k < n; k++) begin
			rnd = lfsr(rnd);
			x = a;
			x.data = rnd;
			x.last = (k == n - 1);
			src.q.push_back(x);
			blk.push_back(rnd);
			if (blk.size() == b || x.last) begin
				evExp++;
				expQ.push_back({1'b1, a.phyOrLink ? 4'h0 : a.ack, a.special ? 4'hE : a.tcode,
					9'(blk.size()), a.speed, snp, x.last, snp ? a.snoopAck : 4'h0, 7'h00});
				while (blk.size() > 0) begin
					expQ.push_back({1'b0, blk.pop_front()});
				end
			end
		end
	endtask

	// Wait for all blocks to be published; a lost event is caught by the hang guard
	task wait_ev();
		while (evCount < evExp) begin
			@(posedge core_clk);
		end
		repeat (4) @(posedge core_clk);
	endtask

	// Read back every entry; status is checked whenever a token is on top
	task drain();
		logic [32:0] q;
		while (expQ.size() > 0) begin
			q = expQ.pop_front();
			if (q[32]) rd(rfrt_pkg::OFF_RXST, {7'h00, q[23:15], 13'h0000, q[11], 2'b11});
			rd(rfrt_pkg::OFF_RXDATA, q[31:0]);
		end
		rd(rfrt_pkg::OFF_RXST, 32'h0000_0000);
	endtask

	task finish_test();
		$display("Comparisons %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence: reset values, normal packet, RAM test, snooped special, split packet,
	// then packets that must stay whole under flush-bad and as quadlet packets
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(rfrt_pkg::OFF_CTRL, 32'h0000_0000);
		rd(rfrt_pkg::OFF_PART, 32'h0080_0080);
		rd(rfrt_pkg::OFF_RXDATA, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000, r, e);
		chk(32'(e), 32'h0000_0001);
		a = '0;
		a.tcode = rnd[3:0];
		a.speed = 2'b10;
		a.ack = 4'h1;
		send(3, 0);
		wait_ev();
		chk(32'(evCount), 32'(evExp));
		wr(rfrt_pkg::OFF_RAMST, 32'h0000_0038);
		for (int i = 0; i < 4; i++) begin
			if (i == 2) wr(rfrt_pkg::OFF_RAMST, 32'h0002_0020);
			rnd = lfsr(rnd);
			ramD[i] = rnd;
			wr(rfrt_pkg::OFF_RXDATA, rnd);
		end
		wr(rfrt_pkg::OFF_RAMST, 32'h0000_0030);
		apb(1'b0, rfrt_pkg::OFF_RXST, 32'h0000_0000, r, e);
		chk(32'(r[1]), 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			rd(rfrt_pkg::OFF_RXDATA, ramD[i]);
		end
		rd(rfrt_pkg::OFF_RAMST, 32'h0004_0034);
		wr(rfrt_pkg::OFF_RAMST, 32'h0000_0028);
		rd(rfrt_pkg::OFF_RAMST, 32'h0000_0020);
		wr(rfrt_pkg::OFF_RAMST, 32'h0000_0000);
		drain();
		snp = 1'b1;
		wr(rfrt_pkg::OFF_CTRL, 32'h0006_0005);
		a.special = 1'b1;
		a.phyOrLink = 1'b1;
		a.snoopAck = 4'h5;
		a.ack = 4'h3;
		a.speed = 2'b00;
		send(8, 6);
		wait_ev();
		chk(32'(evCount), 32'(evExp));
		drain();
		a = '0;
		a.tcode = rnd[7:4];
		a.snoopAck = rnd[11:8];
		a.speed = 2'b01;
		src.slow = 1'b1;
		send(14, 6);
		wait_ev();
		chk(32'(evCount), 32'(evExp));
		drain();
		snp = 1'b0;
		wr(rfrt_pkg::OFF_CTRL, 32'h0006_0003);
		send(7, 0);
		wait_ev();
		wr(rfrt_pkg::OFF_CTRL, 32'h0006_0001);
		a.quadlet = 1'b1;
		send(7, 6);
		wait_ev();
		chk(32'(evCount), 32'(evExp));
		drain();
		finish_test();
	end
endmodule // rfrt_top_test

`default_nettype wire
